// ==== hw/gl_genlock_regs.sv ====
// Genlock offset registers, sync reset and ten-field pulse timing
//
// Decided for this implementation: the Avalon-MM interface to the registers.
module gl_genlock_regs (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ref_hsync,
  input  wire logic        ref_vsync,
  input  wire logic        ten_field_id_in,
  input  wire logic [1:0]  clk_rate_sel,
  output logic             out_hsync,
  output logic             out_vsync,
  output logic             ten_field_id_pulse,
  output logic      [23:0] phase_shift_ps,
  output logic      [15:0] drift_limit,
  output logic             ref_drift_err
);
  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0])
      r[7:0] = wd[7:0];
    if (be[1])
      r[15:8] = wd[15:8];
    return r;
  endfunction

  // Phase increment size for the selected clock rate
  function automatic logic [7:0] step_ps(input logic [1:0] sel);
    logic [7:0] s;
    case (sel)
      2'h0:    s = gl_pkg::STEP_PS_RATE0;
      2'h1:    s = gl_pkg::STEP_PS_RATE1;
      2'h2:    s = gl_pkg::STEP_PS_RATE2;
      default: s = gl_pkg::STEP_PS_RATE3;
    endcase
    return s;
  endfunction

  // Bus and register state
  gl_pkg::gl_bus_st_t bus_st_ff;
  gl_pkg::gl_bus_st_t nxt_bus_st;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        wait_ff;
  logic        nxt_wait;
  logic [5:0]  h_ofs_ff;
  logic [5:0]  nxt_h_ofs;
  logic [15:0] v_ofs_ff;
  logic [15:0] nxt_v_ofs;
  logic [15:0] phase_ff;
  logic [15:0] nxt_phase;
  logic [15:0] drift_ff;
  logic [15:0] nxt_drift;
  logic        tfid_sel_ff;
  logic        nxt_tfid_sel;
  logic        strobe_ff;
  logic        nxt_strobe;
  logic        strobe_high_ff;
  logic        nxt_strobe_high;
  logic        armed_ff;
  logic        nxt_armed;
  logic        arm_set;
  logic        arm_clr;

  // Timing state
  logic        hs_prev_ff;
  logic        vs_prev_ff;
  logic        hs_rise;
  logic        vs_rise;
  logic [5:0]  h_apl_ff;
  logic [5:0]  nxt_h_apl;
  logic [15:0] v_apl_ff;
  logic [15:0] nxt_v_apl;
  logic [15:0] line_cnt_ff;
  logic [15:0] nxt_line_cnt;
  logic [15:0] period_ff;
  logic [15:0] nxt_period;
  logic        drift_err_ff;
  logic        nxt_drift_err;
  logic [15:0] diff;
  logic [3:0]  tf_cnt_ff;
  logic [3:0]  nxt_tf_cnt;
  logic        parity_ff;
  logic        nxt_parity;
  logic        tf_ref_ff;
  logic        nxt_tf_ref;
  logic        tf_pulse_ff;
  logic        nxt_tf_pulse;
  logic [23:0] phase_ps_ff;
  logic [23:0] nxt_phase_ps;

  logic [5:0]  widx;
  logic        wr_take;
  logic [15:0] h_merge;

  gl_delay_if h_dl ();
  gl_delay_if v_dl ();

  assign hs_rise = ref_hsync & ~hs_prev_ff;
  assign vs_rise = ref_vsync & ~vs_prev_ff;
  assign widx    = avs_address[7:2];
  assign wr_take = (bus_st_ff == gl_pkg::GL_BUS_ACK) && avs_write;
  // Horizontal offset widened for the lane merge, cut back to six bits on store
  assign h_merge = merge16({10'h000, h_ofs_ff}, avs_writedata, avs_byteenable);

  // Software strobe: high then written low arms the reset when selected
  assign arm_set = wr_take && (widx == gl_pkg::IDX_SYNC_CTRL) && avs_byteenable[0]
                   && !avs_writedata[gl_pkg::BIT_STROBE] && strobe_high_ff
                   && tfid_sel_ff;
  assign arm_clr = v_dl.fire && parity_ff;

  // Avalon slave: one wait cycle, then a one-cycle answer
  always_comb
  begin
    nxt_bus_st      = bus_st_ff;
    nxt_wait        = 1'b1;
    nxt_rdata       = rdata_ff;
    nxt_h_ofs       = h_ofs_ff;
    nxt_v_ofs       = v_ofs_ff;
    nxt_phase       = phase_ff;
    nxt_drift       = drift_ff;
    nxt_tfid_sel    = tfid_sel_ff;
    nxt_strobe      = strobe_ff;
    nxt_strobe_high = strobe_high_ff;
    case (bus_st_ff)
      gl_pkg::GL_BUS_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          nxt_bus_st = gl_pkg::GL_BUS_ACK;
          nxt_wait   = 1'b0;
          nxt_rdata  = 32'h0000_0000;
          case (widx)
            gl_pkg::IDX_SYNC_CTRL:
            begin
              nxt_rdata[gl_pkg::BIT_STROBE]   = strobe_ff;
              nxt_rdata[gl_pkg::BIT_TFID_SEL] = tfid_sel_ff;
            end
            gl_pkg::IDX_H_OFFSET: nxt_rdata[5:0]  = h_ofs_ff;
            gl_pkg::IDX_V_OFFSET: nxt_rdata[15:0] = v_ofs_ff;
            gl_pkg::IDX_PHASE:    nxt_rdata[15:0] = phase_ff;
            gl_pkg::IDX_DRIFT:    nxt_rdata[15:0] = drift_ff;
            gl_pkg::IDX_STATUS:
            begin
              nxt_rdata[gl_pkg::BIT_ST_DRIFT]  = drift_err_ff;
              nxt_rdata[gl_pkg::BIT_ST_ARMED]  = armed_ff;
              nxt_rdata[gl_pkg::BIT_ST_PARITY] = parity_ff;
              nxt_rdata[gl_pkg::POS_ST_TFCNT +: 4] = tf_cnt_ff;
            end
            default: nxt_rdata = 32'h0000_0000;
          endcase
        end
      end
      gl_pkg::GL_BUS_ACK:
      begin
        nxt_bus_st = gl_pkg::GL_BUS_IDLE;
        if (avs_write)
        begin
          case (widx)
            gl_pkg::IDX_SYNC_CTRL:
            begin
              if (avs_byteenable[0])
              begin
                // Reserved bit is not stored and reads zero
                nxt_strobe   = avs_writedata[gl_pkg::BIT_STROBE];
                nxt_tfid_sel = avs_writedata[gl_pkg::BIT_TFID_SEL];
                if (avs_writedata[gl_pkg::BIT_STROBE])
                  nxt_strobe_high = 1'b1;
                else
                  nxt_strobe_high = 1'b0;
              end
            end
            gl_pkg::IDX_H_OFFSET:
            begin
              nxt_h_ofs = h_merge[gl_pkg::H_OFS_W-1:0];
            end
            gl_pkg::IDX_V_OFFSET: nxt_v_ofs = merge16(v_ofs_ff, avs_writedata, avs_byteenable);
            gl_pkg::IDX_PHASE:    nxt_phase = merge16(phase_ff, avs_writedata, avs_byteenable);
            gl_pkg::IDX_DRIFT:    nxt_drift = merge16(drift_ff, avs_writedata, avs_byteenable);
            default:              nxt_phase = phase_ff;
          endcase
        end
      end
      default: nxt_bus_st = gl_pkg::GL_BUS_IDLE;
    endcase
    // Set wins over the frame-start clear
    nxt_armed = arm_set ? 1'b1 : (arm_clr ? 1'b0 : armed_ff);
  end

  // Register bus and register state
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus_st_ff      <= gl_pkg::GL_BUS_IDLE;
      wait_ff        <= 1'b1;
      rdata_ff       <= 32'h0000_0000;
      h_ofs_ff       <= gl_pkg::H_OFFSET_RST;
      v_ofs_ff       <= gl_pkg::V_OFFSET_RST;
      phase_ff       <= gl_pkg::PHASE_RST;
      drift_ff       <= gl_pkg::DRIFT_RST;
      tfid_sel_ff    <= 1'b0;
      strobe_ff      <= 1'b0;
      strobe_high_ff <= 1'b0;
      armed_ff       <= 1'b0;
    end
    else
    begin
      bus_st_ff      <= nxt_bus_st;
      wait_ff        <= nxt_wait;
      rdata_ff       <= nxt_rdata;
      h_ofs_ff       <= nxt_h_ofs;
      v_ofs_ff       <= nxt_v_ofs;
      phase_ff       <= nxt_phase;
      drift_ff       <= nxt_drift;
      tfid_sel_ff    <= nxt_tfid_sel;
      strobe_ff      <= nxt_strobe;
      strobe_high_ff <= nxt_strobe_high;
      armed_ff       <= nxt_armed;
    end
  end

  // Horizontal delay counts clocks, vertical delay counts reference lines
  assign h_dl.trig = hs_rise;
  assign h_dl.step = 1'b1;
  assign h_dl.dly  = {10'h000, h_apl_ff};
  assign v_dl.trig = vs_rise;
  assign v_dl.step = hs_rise;
  assign v_dl.dly  = v_apl_ff;

  gl_event_delay u_h_delay (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .dl      (h_dl.dev)
  );

  gl_event_delay u_v_delay (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .dl      (v_dl.dev)
  );

  assign diff = (line_cnt_ff > period_ff) ? (line_cnt_ff - period_ff)
                                          : (period_ff - line_cnt_ff);

  // Field sampling, drift check, ten-field sequence and phase product
  always_comb
  begin
    nxt_h_apl     = h_apl_ff;
    nxt_v_apl     = v_apl_ff;
    nxt_line_cnt  = line_cnt_ff;
    nxt_period    = period_ff;
    nxt_drift_err = drift_err_ff;
    nxt_tf_cnt    = tf_cnt_ff;
    nxt_parity    = parity_ff;
    nxt_tf_ref    = tf_ref_ff;
    nxt_tf_pulse  = 1'b0;
    if (vs_rise)
    begin
      nxt_h_apl  = h_ofs_ff;
      nxt_v_apl  = v_ofs_ff;
      nxt_tf_ref = ten_field_id_in;
    end
    if (line_cnt_ff != 16'hffff)
      nxt_line_cnt = line_cnt_ff + 16'h0001;
    if (hs_rise)
    begin
      nxt_line_cnt = 16'h0001;
      nxt_period   = line_cnt_ff;
      if (period_ff != 16'h0000)
        nxt_drift_err = diff > drift_ff;
    end
    if (v_dl.fire)
    begin
      nxt_parity = ~parity_ff;
      if (parity_ff && armed_ff)
      begin
        // Software reset starts a new ten-field sequence at this frame
        nxt_tf_cnt   = 4'h0;
        nxt_tf_pulse = 1'b1;
      end
      else if (tf_ref_ff)
      begin
        nxt_tf_cnt   = 4'h0;
        nxt_tf_pulse = 1'b1;
        nxt_parity   = 1'b1;
        nxt_tf_ref   = 1'b0;
      end
      else if (tf_cnt_ff == gl_pkg::TFID_LAST)
      begin
        nxt_tf_cnt   = 4'h0;
        nxt_tf_pulse = 1'b1;
      end
      else
      begin
        nxt_tf_cnt = tf_cnt_ff + 4'h1;
      end
    end
    nxt_phase_ps = 24'(phase_ff) * 24'(step_ps(clk_rate_sel));
  end

  // Register timing state
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hs_prev_ff   <= 1'b0;
      vs_prev_ff   <= 1'b0;
      h_apl_ff     <= gl_pkg::H_OFFSET_RST;
      v_apl_ff     <= gl_pkg::V_OFFSET_RST;
      line_cnt_ff  <= 16'h0000;
      period_ff    <= 16'h0000;
      drift_err_ff <= 1'b0;
      tf_cnt_ff    <= 4'h0;
      parity_ff    <= 1'b0;
      tf_ref_ff    <= 1'b0;
      tf_pulse_ff  <= 1'b0;
      phase_ps_ff  <= 24'h000000;
    end
    else
    begin
      hs_prev_ff   <= ref_hsync;
      vs_prev_ff   <= ref_vsync;
      h_apl_ff     <= nxt_h_apl;
      v_apl_ff     <= nxt_v_apl;
      line_cnt_ff  <= nxt_line_cnt;
      period_ff    <= nxt_period;
      drift_err_ff <= nxt_drift_err;
      tf_cnt_ff    <= nxt_tf_cnt;
      parity_ff    <= nxt_parity;
      tf_ref_ff    <= nxt_tf_ref;
      tf_pulse_ff  <= nxt_tf_pulse;
      phase_ps_ff  <= nxt_phase_ps;
    end
  end

  // Outputs straight from flip-flops
  assign avs_readdata       = rdata_ff;
  assign avs_waitrequest    = wait_ff;
  assign out_hsync          = h_dl.fire;
  assign out_vsync          = v_dl.fire;
  assign ten_field_id_pulse = tf_pulse_ff;
  assign phase_shift_ps     = phase_ps_ff;
  assign drift_limit        = drift_ff;
  assign ref_drift_err      = drift_err_ff;
endmodule

// ==== hw/gl_pkg.sv ====
// Shared constants and types for the genlock offset and sync reset block
package gl_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_SYNC_CTRL = 6'h1a;
  localparam logic [5:0] IDX_H_OFFSET  = 6'h1b;
  localparam logic [5:0] IDX_V_OFFSET  = 6'h1c;
  localparam logic [5:0] IDX_PHASE     = 6'h1d;
  localparam logic [5:0] IDX_DRIFT     = 6'h1e;
  localparam logic [5:0] IDX_STATUS    = 6'h30;

  // Sync reset control fields
  localparam int unsigned BIT_STROBE   = 0;
  localparam int unsigned BIT_RSVD     = 1;
  localparam int unsigned BIT_TFID_SEL = 2;

  // Status fields
  localparam int unsigned BIT_ST_DRIFT  = 0;
  localparam int unsigned BIT_ST_ARMED  = 1;
  localparam int unsigned BIT_ST_PARITY = 2;
  localparam int unsigned POS_ST_TFCNT  = 4;

  // Field widths
  localparam int unsigned H_OFS_W = 6;
  localparam int unsigned REG_W   = 16;

  // Values after reset
  localparam logic [5:0]  H_OFFSET_RST = 6'h00;
  localparam logic [15:0] V_OFFSET_RST = 16'h0000;
  localparam logic [15:0] PHASE_RST    = 16'h0000;
  localparam logic [15:0] DRIFT_RST    = 16'h000b;

  // Ten-field sequence: last count of the field counter
  localparam logic [3:0] TFID_LAST = 4'h9;

  // Phase increment in picoseconds per selected video clock rate
  localparam logic [7:0] STEP_PS_RATE0 = 8'hc8;
  localparam logic [7:0] STEP_PS_RATE1 = 8'h96;
  localparam logic [7:0] STEP_PS_RATE2 = 8'h7d;
  localparam logic [7:0] STEP_PS_RATE3 = 8'h64;

  // Bus handshake states
  typedef enum {GL_BUS_IDLE, GL_BUS_ACK} gl_bus_st_t;
endpackage

// ==== hw/gl_delay_if.sv ====
// Carrier between the timing top and an event delay unit
interface gl_delay_if;
  logic        trig;
  logic        step;
  logic [15:0] dly;
  logic        fire;

  modport dev (input trig, input step, input dly, output fire);
  modport ctl (output trig, output step, output dly, input fire);
endinterface

// ==== hw/gl_event_delay.sv ====
// Delays one event by a programmable number of step ticks
module gl_event_delay (
  input wire logic sys_clk,
  input wire logic resetn,
  gl_delay_if.dev  dl
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic        busy_ff;
  logic        nxt_busy;
  logic        fire_ff;
  logic        nxt_fire;

  // Load on trigger, count steps, fire when the count runs out
  always_comb
  begin
    nxt_cnt  = cnt_ff;
    nxt_busy = busy_ff;
    nxt_fire = 1'b0;
    if (dl.trig)
    begin
      if (dl.dly == 16'h0000)
      begin
        nxt_fire = 1'b1; // Zero delay passes the event straight on
        nxt_busy = 1'b0;
      end
      else
      begin
        nxt_cnt  = dl.dly;
        nxt_busy = 1'b1;
      end
    end
    else if (busy_ff && dl.step)
    begin
      if (cnt_ff == 16'h0001)
      begin
        nxt_fire = 1'b1;
        nxt_busy = 1'b0;
      end
      else
      begin
        nxt_cnt = cnt_ff - 16'h0001;
      end
    end
  end

  // Register the counter state
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_ff  <= 16'h0000;
      busy_ff <= 1'b0;
      fire_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
      fire_ff <= nxt_fire;
    end
  end

  assign dl.fire = fire_ff;
endmodule

// ==== test/gl_genlock_regs_assertions.sv ====
// Port checker for the genlock register block
module gl_genlock_regs_assertions (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        ref_hsync,
  input wire logic        ref_vsync,
  input wire logic [1:0]  clk_rate_sel,
  input wire logic        out_hsync,
  input wire logic        out_vsync,
  input wire logic        ten_field_id_pulse,
  input wire logic [23:0] phase_shift_ps,
  input wire logic [15:0] drift_limit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Bus request and its one-cycle answer
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_answer; s_req |=> s_ack; endproperty
  property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_drift_rst; $rose(resetn) |-> drift_limit == 16'h000b; endproperty
  property p_hs_delay; $rose(ref_hsync) |-> ##[1:64] out_hsync; endproperty
  property p_hs_one; out_hsync |=> !out_hsync; endproperty
  property p_vs_cause; out_vsync |-> $past(ref_hsync) || $past(ref_vsync); endproperty
  property p_tf_vs;
    ten_field_id_pulse |-> $past(out_vsync) && !$past(ten_field_id_pulse);
  endproperty
  property p_phase_step;
    $stable(clk_rate_sel) && clk_rate_sel == 2'h0 |-> phase_shift_ps % 24'h0000c8 == 24'h0;
  endproperty
  property p_drift_wr;
    $changed(drift_limit) |-> $past(avs_write) && !$past(avs_waitrequest);
  endproperty

  a_answer: assert property (p_answer) else $error("bus request not answered");
  a_wait_one: assert property (p_wait_one) else $error("answer longer than a cycle");
  a_drift_rst: assert property (p_drift_rst) else $error("drift limit reset");
  a_hs_delay: assert property (p_hs_delay) else $error("line event lost");
  a_hs_one: assert property (p_hs_one) else $error("line pulse too long");
  a_vs_cause: assert property (p_vs_cause) else $error("field pulse uncaused");
  a_tf_vs: assert property (p_tf_vs) else $error("ten-field pulse misplaced");
  a_phase_step: assert property (p_phase_step) else $error("phase step size");
  a_drift_wr: assert property (p_drift_wr) else $error("drift limit moved");
endmodule

bind gl_genlock_regs gl_genlock_regs_assertions u_gl_genlock_regs_assertions (
  .sys_clk, .resetn, .avs_read, .avs_write, .avs_waitrequest, .ref_hsync, .ref_vsync,
  .clk_rate_sel, .out_hsync, .out_vsync, .ten_field_id_pulse, .phase_shift_ps, .drift_limit
);

// ==== test/gl_ref_source.sv ====
// Reference video sync source driving the genlock block
module gl_ref_source #(
  parameter int LINE_CYC = 100,
  parameter int FIELD_LN = 4
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] line_extra,
  output logic            ref_hsync,
  output logic            ref_vsync,
  output logic            ten_field_id_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int pix_ff;
  int line_ff;

  // Pixel and line position; extra cycles stretch a line, change them early in a line only
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pix_ff  <= 0;
      line_ff <= 0;
    end
    else if (pix_ff == LINE_CYC - 1 + int'(line_extra))
    begin
      pix_ff  <= 0;
      line_ff <= (line_ff == FIELD_LN - 1) ? 0 : line_ff + 1;
    end
    else
      pix_ff <= pix_ff + 1;
  end

  // Four-cycle syncs; field sync sits mid-line so offsets stay inside a line
  assign ref_hsync = pix_ff < 4;
  assign ref_vsync = line_ff == 0 && pix_ff >= LINE_CYC / 2 && pix_ff < LINE_CYC / 2 + 4;
  // No ten-field reference present
  assign ten_field_id_in = 1'b0;
endmodule

// ==== test/gl_genlock_regs_test.sv ====
// Self-checking bench for the genlock offset and sync reset block
module gl_genlock_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk;
  logic        resetn;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ref_hsync;
  logic        ref_vsync;
  logic        ten_field_id_in;
  logic [1:0]  clk_rate_sel;
  logic        out_hsync;
  logic        out_vsync;
  logic        ten_field_id_pulse;
  logic [23:0] phase_shift_ps;
  logic [15:0] drift_limit;
  logic        ref_drift_err;
  logic [7:0]  line_extra;
  int          fails;
  int          checked;

  gl_genlock_regs u_gl_genlock_regs (
    .sys_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .ref_hsync, .ref_vsync,
    .ten_field_id_in, .clk_rate_sel, .out_hsync, .out_vsync, .ten_field_id_pulse,
    .phase_shift_ps, .drift_limit, .ref_drift_err
  );
  gl_ref_source u_gl_ref_source (.sys_clk, .resetn, .ref_hsync, .ref_vsync, .ten_field_id_in,
                                 .line_extra);

  // Clock
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  task automatic summarize;
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr_en, input logic [5:0] idx, input logic [15:0] wd,
                     output logic [31:0] rd_data);
    @(posedge sys_clk);
    avs_address   <= {idx, 2'h0};
    avs_write     <= wr_en;
    avs_read      <= ~wr_en;
    avs_writedata <= {16'h0000, wd};
    do
      @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0);
    rd_data = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [15:0] e);
    logic [31:0] r;
    bus(1'b0, idx, 16'h0000, r);
    chk(r, {16'h0000, e});
  endtask

  // Cycles from a line event to the delayed line pulse
  task automatic hdelay(output int d);
    @(posedge ref_hsync);
    d = 0;
    do
    begin
      @(posedge sys_clk);
      d++;
    end
    while (out_hsync !== 1'b1);
  endtask

  // Line events between a field event and the delayed field pulse
  task automatic vcount(output int n);
    logic p;
    n = 0;
    @(posedge ref_vsync);
    p = 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (ref_hsync === 1'b1 && p === 1'b0)
        n++;
      p = ref_hsync;
    end
    while (out_vsync !== 1'b1);
  endtask

  // Field pulses up to and including the next ten-field pulse
  task automatic wait_tf(output int n);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      if (out_vsync === 1'b1)
        n++;
    end
    while (ten_field_id_pulse !== 1'b1);
  endtask

  task automatic t_regs;
    rd(gl_pkg::IDX_DRIFT, 16'h000b);
    rd(gl_pkg::IDX_V_OFFSET, 16'h0000);
    rd(gl_pkg::IDX_PHASE, 16'h0000);
    chk(32'(drift_limit), 32'h0000000b);
    wr(6'h00, 16'hffff);
    rd(6'h00, 16'h0000);
    wr(gl_pkg::IDX_DRIFT, 16'h0020);
    rd(gl_pkg::IDX_DRIFT, 16'h0020);
    chk(32'(drift_limit), 32'h00000020);
  endtask

  task automatic t_phase;
    logic [7:0] stp [4] = '{gl_pkg::STEP_PS_RATE0, gl_pkg::STEP_PS_RATE1,
                            gl_pkg::STEP_PS_RATE2, gl_pkg::STEP_PS_RATE3};
    wr(gl_pkg::IDX_PHASE, 16'h0003);
    for (int i = 0; i < 4; i++)
    begin
      clk_rate_sel <= 2'(i);
      repeat (3) @(posedge sys_clk);
      chk(32'(phase_shift_ps), 32'(stp[i]) * 32'h3);
    end
    wr(gl_pkg::IDX_PHASE, 16'h0000);
    repeat (3) @(posedge sys_clk);
    chk(32'(phase_shift_ps), 32'h0);
  endtask

  task automatic t_hofs;
    int d0;
    int d1;
    @(posedge ref_vsync);
    hdelay(d0);
    wr(gl_pkg::IDX_H_OFFSET, 16'h0005);
    hdelay(d1);
    chk(32'(d1), 32'(d0));
    repeat (2) @(posedge ref_vsync);
    hdelay(d1);
    chk(32'(d1 - d0), 32'h5);
    // Advance of four pixels against the largest six-bit offset
    wr(gl_pkg::IDX_H_OFFSET, 16'h003b);
    @(posedge ref_vsync);
    hdelay(d1);
    chk(32'(d1 - d0), 32'h3b);
  endtask

  task automatic t_vofs;
    int n;
    vcount(n);
    chk(32'(n), 32'h0);
    wr(gl_pkg::IDX_V_OFFSET, 16'h0002);
    vcount(n);
    chk(32'(n), 32'h0);
    vcount(n);
    chk(32'(n), 32'h2);
    // One line of advance against a four-line field
    wr(gl_pkg::IDX_V_OFFSET, 16'h0003);
    vcount(n);
    chk(32'(n), 32'h2);
    vcount(n);
    chk(32'(n), 32'h3);
  endtask

  task automatic t_tfid;
    int n;
    wait_tf(n);
    repeat (3) @(posedge out_vsync);
    wr(gl_pkg::IDX_SYNC_CTRL, 16'h0005);
    wr(gl_pkg::IDX_SYNC_CTRL, 16'h0004);
    wait_tf(n);
    chk(32'(n <= 2), 32'h1);
    wait_tf(n);
    chk(32'(n), 32'ha);
    // Strobe with the select bit low must leave the sequence running
    repeat (3) @(posedge out_vsync);
    wr(gl_pkg::IDX_SYNC_CTRL, 16'h0001);
    wr(gl_pkg::IDX_SYNC_CTRL, 16'h0000);
    wait_tf(n);
    chk(32'(n), 32'h7);
  endtask

  // Line length steps against the drift limit of 0x20 set earlier
  task automatic t_drift;
    logic [31:0] r;
    @(posedge ref_hsync);
    @(posedge sys_clk);
    line_extra <= 8'h10;
    @(posedge ref_hsync);
    @(posedge sys_clk);
    line_extra <= 8'h40;
    repeat (2) @(posedge sys_clk);
    chk(32'(ref_drift_err), 32'h0);
    @(posedge ref_hsync);
    @(posedge sys_clk);
    line_extra <= 8'h00;
    repeat (2) @(posedge sys_clk);
    chk(32'(ref_drift_err), 32'h1);
    bus(1'b0, gl_pkg::IDX_STATUS, 16'h0000, r);
    chk(32'(r[gl_pkg::BIT_ST_DRIFT]), 32'h1);
    repeat (2) @(posedge ref_hsync);
    repeat (3) @(posedge sys_clk);
    chk(32'(ref_drift_err), 32'h0);
  endtask

  // Watchdog
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    fails++;
    summarize();
  end

  initial
  begin
    fails = 0;
    checked = 0;
    resetn = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    clk_rate_sel = 2'h0;
    line_extra = 8'h00;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    t_regs();
    t_phase();
    t_hofs();
    t_vofs();
    t_tfid();
    t_drift();
    summarize();
  end
endmodule
